// ==== rtl/sid_pkg.sv ====
// Purpose: shared constants and types of the serial channel data path
// Assumes: 32-bit classic Wishbone register access, byte addresses
// Notes:   register offsets are byte addresses of aligned words
package sid_pkg;
  localparam logic [7:0] ADDR_RX_HOLD = 8'h00;
  localparam logic [7:0] ADDR_TX_HOLD = 8'h04;
  localparam logic [7:0] ADDR_MODE    = 8'h08;
  localparam logic [7:0] ADDR_CTRL    = 8'h0C;
  localparam logic [7:0] ADDR_STATE   = 8'h10;
  localparam logic [7:0] ADDR_RATE    = 8'h14;
  // Mode register bits
  localparam int MODE_SYNC     = 0;
  localparam int MODE_CHAR7    = 1;
  localparam int MODE_PAR_EN   = 2;
  localparam int MODE_PAR_ODD  = 3;
  localparam int MODE_TWO_STOP = 4;
  localparam int MODE_MSB      = 5;
  localparam int MODE_SMART    = 6;
  localparam int MODE_EXT_CLK  = 7;
  localparam int MODE_INVERSE  = 8;
  // Control register bits
  localparam int CTRL_TX_EN = 0;
  localparam int CTRL_RX_EN = 1;
  // Serial state register bits
  localparam int ST_TX_EMPTY = 0;
  localparam int ST_RX_FULL  = 1;
  localparam int ST_OVERRUN  = 2;
  localparam int ST_FRAMING  = 3;
  localparam int ST_PARITY   = 4;
  localparam int ST_TX_END   = 5;
  localparam int ST_RX_PIN   = 6;
  // Reset values
  localparam logic [8:0] MODE_RESET = 9'h000;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [7:0] RATE_RESET = 8'h00;
  localparam logic [7:0] HOLD_RESET = 8'h00;
  // Oversampling and data constants
  localparam logic [3:0] SUB_LAST   = 4'hF;
  localparam logic [3:0] SUB_MID    = 4'h7;
  localparam logic [3:0] SYNC_MID   = 4'h8;
  localparam logic [2:0] LAST_BIT8  = 3'h7;
  localparam logic [2:0] LAST_BIT7  = 3'h6;
  localparam logic [7:0] MASK7      = 8'h7F;
  localparam logic [7:0] MASK8      = 8'hFF;
  typedef enum logic [2:0] {
    TX_IDLE   = 3'h0,
    TX_START  = 3'h1,
    TX_DATA   = 3'h2,
    TX_PARITY = 3'h3,
    TX_STOP   = 3'h4,
    TX_GUARD  = 3'h5
  } sid_tx_state_t;
  typedef enum logic [2:0] {
    RX_IDLE   = 3'h0,
    RX_START  = 3'h1,
    RX_DATA   = 3'h2,
    RX_PARITY = 3'h3,
    RX_STOP   = 3'h4,
    RX_ERRSIG = 3'h5
  } sid_rx_state_t;
endpackage : sid_pkg

// ==== rtl/sid_serial_channel.sv ====
// Purpose: one serial channel data path with holding and shift registers
// Assumes: 20 MHz i_clock, pins synchronised here, 16x oversampling
// Notes:   async, clocked sync and smart card framing
`timescale 1ns/1ps
// Notes on behaviour
// - Receive shifter deserialises pin and moves full byte to holding.
// - Receive holding is 8 bits and ignores bus writes.
// - Receive shifter is ready for the next character at once.
// - Empty transmit shifter takes holding content and starts shifting.
// - Waiting holding content follows current character with no gap.
// - Transmit holding is 8 bits, readable and writable any time.
// - Transmit shifter drives the pin and is not bus visible.
// - Transmitter and receiver run independently, full duplex.
// - Async characters are 7 or 8 data bits.
// - Async frame has one or two stop bits, even, odd or no parity.
// - Async receiver flags parity, overrun and framing errors.
// - Clocked sync uses 8-bit characters and flags only overrun.
// - Bit order selectable, except fixed for 7-bit async and inverse smart card.
// - Four requests: transmit end, transmit empty, receive full, error.
// - Empty and full requests also trigger the transfer controller.
// - Software can read the receive pin level directly.
// - Clock from baud divider or external pin outside smart card.
// - Smart card receiver drives error signal on parity error.
// - Smart card transmitter resends on error signal; both conventions.
// - 7-bit async is LSB first and holding top bit is not sent.
// - Receiver checks only first stop bit; low second one starts.
module sid_serial_channel (
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  input  wire logic        i_rxd,
  output logic             o_txd,
  input  wire logic        i_sck,
  output logic             o_sck,
  output logic             o_sck_oe_n,
  output logic             o_req_tx_end,
  output logic             o_req_tx_empty,
  output logic             o_req_rx_full,
  output logic             o_req_rx_error,
  output logic             o_xfer_tx_start,
  output logic             o_xfer_rx_start
);
  import sid_pkg::*;

  function automatic logic pick_bit(input logic [7:0] d, input logic [2:0] i, input logic m);
    pick_bit = m ? d[3'h7 - i] : d[i];
  endfunction : pick_bit

  function automatic logic [7:0] put_bit(input logic [7:0] d, input logic [2:0] i,
                                         input logic m, input logic b);
    put_bit = d;
    if (m) begin
      put_bit[3'h7 - i] = b;
    end else begin
      put_bit[i] = b;
    end
  endfunction : put_bit

  function automatic logic par_of(input logic [7:0] d, input logic c7, input logic odd);
    par_of = (^(d & (c7 ? MASK7 : MASK8))) ^ odd;
  endfunction : par_of

  logic          rxd_meta_reg, rxd_sync_reg, sck_meta_reg, sck_sync_reg, sck_prev_reg;
  logic [8:0]    mode_reg;
  logic [1:0]    ctrl_reg;
  logic [7:0]    rate_reg, rate_cnt_reg;
  logic [7:0]    transmit_holding_reg, receive_holding_reg;
  logic          tx_empty_reg, tx_end_reg, rx_full_reg;
  logic          overrun_reg, framing_reg, parity_reg;
  logic          ack_reg, sck_out_reg, txd_reg, xfer_tx_reg, xfer_rx_reg;
  logic [31:0]   dat_reg;
  logic [3:0]    sync_sub_reg, tx_sub_reg, rx_sub_reg;
  sid_tx_state_t tx_state_reg, tx_state_next;
  logic [2:0]    tx_idx_reg, tx_idx_next;
  logic          tx_stop2_reg, tx_stop2_next, tx_resend_reg, tx_resend_next;
  logic [7:0]    tx_shift_reg;
  sid_rx_state_t rx_state_reg, rx_state_next;
  logic [2:0]    rx_idx_reg, rx_idx_next;
  logic [7:0]    rx_shift_reg, rx_shift_next;
  logic          rx_par_reg, rx_par_next;
  logic          tx_line;
  logic [31:0]   state_word;

  // Pin synchronisers
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rxd_meta_reg <= 1'b1;
      rxd_sync_reg <= 1'b1;
      sck_meta_reg <= 1'b1;
      sck_sync_reg <= 1'b1;
      sck_prev_reg <= 1'b1;
    end else begin
      rxd_meta_reg <= i_rxd;
      rxd_sync_reg <= rxd_meta_reg;
      sck_meta_reg <= i_sck;
      sck_sync_reg <= sck_meta_reg;
      sck_prev_reg <= sck_sync_reg;
    end
  end

  // Configuration decode
  wire smart     = mode_reg[MODE_SMART];
  wire sync_mode = mode_reg[MODE_SYNC] & ~smart;
  wire char7     = mode_reg[MODE_CHAR7] & ~sync_mode & ~smart;
  wire par_en    = smart | (mode_reg[MODE_PAR_EN] & ~sync_mode);
  wire par_odd   = par_en & mode_reg[MODE_PAR_ODD];
  wire two_stop  = mode_reg[MODE_TWO_STOP] & ~sync_mode & ~smart;
  wire inverse   = smart & mode_reg[MODE_INVERSE];
  wire msb_first = inverse | (mode_reg[MODE_MSB] & ~char7);
  // External clock only outside smart card
  wire ext_clk   = mode_reg[MODE_EXT_CLK] & ~smart;
  wire [2:0] last_idx = char7 ? LAST_BIT7 : LAST_BIT8;
  wire tx_en     = ctrl_reg[CTRL_TX_EN];
  wire rx_en     = ctrl_reg[CTRL_RX_EN];

  // Clock sources
  wire int_tick  = (rate_cnt_reg == rate_reg);
  wire sck_rise  = sck_sync_reg & ~sck_prev_reg;
  wire sck_fall  = ~sck_sync_reg & sck_prev_reg;
  wire tick      = ext_clk ? sck_rise : int_tick;
  wire sync_run  = sync_mode & ((tx_state_reg != TX_IDLE) | (tx_en & ~tx_empty_reg) | rx_en);
  wire bit_start = sync_run & (ext_clk ? sck_fall : (int_tick & (sync_sub_reg == 4'h0)));
  wire bit_mid   = sync_run & (ext_clk ? sck_rise : (int_tick & (sync_sub_reg == SYNC_MID)));

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rate_cnt_reg <= 8'h00;
      sync_sub_reg <= 4'h0;
      sck_out_reg  <= 1'b1;
    end else begin
      rate_cnt_reg <= int_tick ? 8'h00 : rate_cnt_reg + 8'h01;
      sync_sub_reg <= !sync_run ? 4'h0 : (int_tick ? sync_sub_reg + 4'h1 : sync_sub_reg);
      sck_out_reg  <= ~sync_run | sync_sub_reg[3];
    end
  end

  // Bus decode
  wire wb_req  = i_wb_cyc & i_wb_stb & ~ack_reg;
  wire wr      = wb_req & i_wb_we;
  wire rd      = wb_req & ~i_wb_we;
  wire wr_lo   = wr & i_wb_sel[0];
  wire wr_txh  = wr_lo & (i_wb_adr == ADDR_TX_HOLD);
  wire wr_st   = wr_lo & (i_wb_adr == ADDR_STATE);
  wire rd_rxh  = rd & (i_wb_adr == ADDR_RX_HOLD);

  // Transmit control
  wire tx_adv  = sync_mode ? bit_start : (tick & (tx_sub_reg == SUB_LAST));
  wire tx_mid  = tick & (tx_sub_reg == SUB_MID);
  wire tx_last_end = tx_adv & (
    (sync_mode & (tx_state_reg == TX_DATA) & (tx_idx_reg == last_idx)) |
    (~smart & (tx_state_reg == TX_STOP) & (~two_stop | tx_stop2_reg)) |
    ((tx_state_reg == TX_GUARD) & ~tx_resend_reg));
  wire tx_load = tx_en & ~tx_empty_reg &
                 (((tx_state_reg == TX_IDLE) & (~sync_mode | bit_start)) | tx_last_end);

  always_comb begin
    tx_state_next  = tx_state_reg;
    tx_idx_next    = tx_idx_reg;
    tx_stop2_next  = tx_stop2_reg;
    tx_resend_next = tx_resend_reg;
    if (tx_load) begin
      tx_state_next  = sync_mode ? TX_DATA : TX_START;
      tx_idx_next    = 3'h0;
      tx_stop2_next  = 1'b0;
      tx_resend_next = 1'b0;
    end else if (!tx_en) begin
      tx_state_next = TX_IDLE;
    end else if (tx_adv) begin
      case (tx_state_reg)
        TX_START: begin
          tx_state_next = TX_DATA;
          tx_idx_next   = 3'h0;
        end
        TX_DATA: begin
          if (tx_idx_reg == last_idx) begin
            tx_state_next = sync_mode ? TX_IDLE : (par_en ? TX_PARITY : TX_STOP);
          end else begin
            tx_idx_next = tx_idx_reg + 3'h1;
          end
        end
        TX_PARITY: tx_state_next = TX_STOP;
        TX_STOP: begin
          if (smart) begin
            tx_state_next = TX_GUARD;
          end else if (two_stop & ~tx_stop2_reg) begin
            tx_stop2_next = 1'b1;
          end else begin
            tx_state_next = TX_IDLE;
          end
        end
        TX_GUARD: begin
          tx_state_next  = tx_resend_reg ? TX_START : TX_IDLE;
          tx_resend_next = 1'b0;
        end
        default: tx_state_next = TX_IDLE;
      endcase
    end else if ((tx_state_reg == TX_GUARD) && tx_mid && !rxd_sync_reg) begin
      tx_resend_next = 1'b1;
    end
  end

  always_comb begin
    case (tx_state_reg)
      TX_START:  tx_line = 1'b0;
      TX_DATA:   tx_line = pick_bit(tx_shift_reg, tx_idx_reg, msb_first) ^ inverse;
      TX_PARITY: tx_line = par_of(tx_shift_reg, char7, par_odd) ^ inverse;
      default:   tx_line = 1'b1;
    endcase
  end

  // Transmit path runs on its own counters
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_state_reg  <= TX_IDLE;
      tx_idx_reg    <= 3'h0;
      tx_stop2_reg  <= 1'b0;
      tx_resend_reg <= 1'b0;
      tx_sub_reg    <= 4'h0;
      tx_shift_reg  <= HOLD_RESET;
    end else begin
      tx_state_reg  <= tx_state_next;
      tx_idx_reg    <= tx_idx_next;
      tx_stop2_reg  <= tx_stop2_next;
      tx_resend_reg <= tx_resend_next;
      tx_sub_reg    <= tx_load ? 4'h0 : (tick ? tx_sub_reg + 4'h1 : tx_sub_reg);
      if (tx_load) begin
        tx_shift_reg <= transmit_holding_reg;
      end
    end
  end

  // Receive control
  wire rx_sample = sync_mode ? bit_mid : (tick & (rx_sub_reg == SUB_MID));
  wire rx_bit    = rxd_sync_reg ^ inverse;
  wire rx_done   = rx_en & rx_sample &
                   ((rx_state_reg == RX_STOP) |
                    (sync_mode & (rx_state_reg == RX_DATA) & (rx_idx_reg == last_idx)));
  wire par_bad   = par_en & (par_of(rx_shift_reg, char7, par_odd) != rx_par_reg);

  always_comb begin
    rx_state_next = rx_state_reg;
    rx_idx_next   = rx_idx_reg;
    rx_shift_next = rx_shift_reg;
    rx_par_next   = rx_par_reg;
    if (!rx_en) begin
      rx_state_next = RX_IDLE;
    end else begin
      case (rx_state_reg)
        RX_IDLE: begin
          rx_idx_next = 3'h0;
          if (sync_mode) begin
            rx_state_next = RX_DATA;
          end else if (!rxd_sync_reg) begin
            rx_state_next = RX_START;
            rx_shift_next = 8'h00;
          end
        end
        RX_START: begin
          if (rx_sample) begin
            rx_state_next = rxd_sync_reg ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_sample) begin
            rx_shift_next = put_bit(rx_shift_reg, rx_idx_reg, msb_first, rx_bit);
            rx_idx_next   = rx_idx_reg + 3'h1;
            if (rx_idx_reg == last_idx) begin
              rx_idx_next   = 3'h0;
              rx_state_next = sync_mode ? RX_DATA : (par_en ? RX_PARITY : RX_STOP);
            end
          end
        end
        RX_PARITY: begin
          if (rx_sample) begin
            rx_par_next   = rx_bit;
            rx_state_next = RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_sample) begin
            rx_state_next = (smart & par_bad) ? RX_ERRSIG : RX_IDLE;
          end
        end
        RX_ERRSIG: begin
          if (rx_sample) begin
            rx_state_next = RX_IDLE;
          end
        end
        default: rx_state_next = RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_state_reg <= RX_IDLE;
      rx_idx_reg   <= 3'h0;
      rx_shift_reg <= 8'h00;
      rx_par_reg   <= 1'b0;
      rx_sub_reg   <= 4'h0;
      txd_reg      <= 1'b1;
    end else begin
      rx_state_reg <= rx_state_next;
      rx_idx_reg   <= rx_idx_next;
      rx_shift_reg <= rx_shift_next;
      rx_par_reg   <= rx_par_next;
      rx_sub_reg   <= (rx_state_reg == RX_IDLE) ? 4'h0 : (tick ? rx_sub_reg + 4'h1 : rx_sub_reg);
      txd_reg      <= tx_line & (rx_state_reg != RX_ERRSIG);
    end
  end

  // Holding registers and flags, set wins over clear
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      transmit_holding_reg <= HOLD_RESET;
      receive_holding_reg  <= HOLD_RESET;
      tx_empty_reg <= 1'b1;
      tx_end_reg   <= 1'b1;
      rx_full_reg  <= 1'b0;
      overrun_reg  <= 1'b0;
      framing_reg  <= 1'b0;
      parity_reg   <= 1'b0;
      xfer_tx_reg  <= 1'b0;
      xfer_rx_reg  <= 1'b0;
    end else begin
      if (wr_txh) begin
        transmit_holding_reg <= i_wb_dat[7:0];
      end
      // Empty flag on move to shifter
      tx_empty_reg <= tx_load | (tx_empty_reg & ~wr_txh);
      tx_end_reg   <= (tx_last_end & ~tx_load) | (tx_end_reg & ~wr_txh);
      // Only receive path loads, older byte kept
      if (rx_done && !rx_full_reg) begin
        receive_holding_reg <= rx_shift_next;
      end
      rx_full_reg  <= (rx_done & ~rx_full_reg) | (rx_full_reg & ~rd_rxh);
      overrun_reg  <= (rx_done & rx_full_reg) | (overrun_reg & ~(wr_st & i_wb_dat[ST_OVERRUN]));
      framing_reg  <= (rx_done & ~sync_mode & ~rxd_sync_reg) |
                      (framing_reg & ~(wr_st & i_wb_dat[ST_FRAMING]));
      parity_reg   <= (rx_done & ~sync_mode & par_bad) |
                      (parity_reg & ~(wr_st & i_wb_dat[ST_PARITY]));
      xfer_tx_reg  <= tx_load;
      xfer_rx_reg  <= rx_done & ~rx_full_reg;
    end
  end

  // Register file
  always_comb begin
    state_word = 32'h0000_0000;
    state_word[ST_TX_EMPTY] = tx_empty_reg;
    state_word[ST_RX_FULL]  = rx_full_reg;
    state_word[ST_OVERRUN]  = overrun_reg;
    state_word[ST_FRAMING]  = framing_reg;
    state_word[ST_PARITY]   = parity_reg;
    state_word[ST_TX_END]   = tx_end_reg;
    state_word[ST_RX_PIN]   = rxd_sync_reg;
  end

  wire [31:0] rd_data =
    (i_wb_adr == ADDR_RX_HOLD) ? {24'h000000, receive_holding_reg} :
    (i_wb_adr == ADDR_TX_HOLD) ? {24'h000000, transmit_holding_reg} :
    (i_wb_adr == ADDR_MODE)    ? {23'h0, mode_reg} :
    (i_wb_adr == ADDR_CTRL)    ? {30'h0, ctrl_reg} :
    (i_wb_adr == ADDR_STATE)   ? state_word :
    (i_wb_adr == ADDR_RATE)    ? {24'h000000, rate_reg} : 32'h0000_0000;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      mode_reg <= MODE_RESET;
      ctrl_reg <= CTRL_RESET;
      rate_reg <= RATE_RESET;
      ack_reg  <= 1'b0;
      dat_reg  <= 32'h0000_0000;
    end else begin
      ack_reg <= wb_req;
      if (rd) begin
        dat_reg <= rd_data;
      end
      if (wr_lo && (i_wb_adr == ADDR_MODE)) begin
        mode_reg[7:0] <= i_wb_dat[7:0];
      end
      if (wr && i_wb_sel[1] && (i_wb_adr == ADDR_MODE)) begin
        mode_reg[MODE_INVERSE] <= i_wb_dat[MODE_INVERSE];
      end
      if (wr_lo && (i_wb_adr == ADDR_CTRL)) begin
        ctrl_reg <= i_wb_dat[1:0];
      end
      if (wr_lo && (i_wb_adr == ADDR_RATE)) begin
        rate_reg <= i_wb_dat[7:0];
      end
    end
  end

  assign o_wb_ack   = ack_reg;
  assign o_wb_dat   = dat_reg;
  assign o_txd      = txd_reg;
  assign o_sck      = sck_out_reg;
  assign o_sck_oe_n = ~(sync_mode & ~ext_clk);
  assign o_req_tx_end    = tx_end_reg;
  assign o_req_tx_empty  = tx_empty_reg;
  assign o_req_rx_full   = rx_full_reg;
  assign o_req_rx_error  = overrun_reg | framing_reg | parity_reg;
  assign o_xfer_tx_start = xfer_tx_reg;
  assign o_xfer_rx_start = xfer_rx_reg;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  a_rx_move_full: assert property (rx_done && !rx_full_reg |=> rx_full_reg &&
    receive_holding_reg == $past(rx_shift_next)) else $error("received byte not moved");
  a_rx_hold_ro: assert property (wr && i_wb_adr == ADDR_RX_HOLD && !rx_done
    |=> $stable(receive_holding_reg)) else $error("receive holding changed by write");
  a_rx_ready_next: assert property (rx_done && !sync_mode && !smart
    |=> rx_state_reg == RX_IDLE) else $error("receiver not ready after byte");
  a_tx_load_empty: assert property (tx_load |=> tx_empty_reg && o_xfer_tx_start
    && tx_shift_reg == $past(transmit_holding_reg)) else $error("holding not moved");
  a_tx_no_gap: assert property (tx_last_end && !tx_empty_reg && tx_en && !sync_mode
    |=> tx_state_reg == TX_START ##1 txd_reg == 1'b0) else $error("gap between characters");
  a_tx_idle_high: assert property (tx_state_reg == TX_IDLE && rx_state_reg != RX_ERRSIG
    |=> txd_reg) else $error("idle line not high");
  a_rx_overrun: assert property (rx_done && rx_full_reg |=> overrun_reg
    && $stable(receive_holding_reg)) else $error("overrun not flagged");
  a_seven_bits: assert property (char7 && tx_state_reg == TX_DATA
    |-> tx_idx_reg <= LAST_BIT7) else $error("top bit sent in 7-bit mode");
  a_sync_no_frame: assert property (sync_mode && rx_done && !framing_reg && !parity_reg
    |=> !framing_reg && !parity_reg) else $error("framing flag in sync mode");
  a_smart_errsig: assert property (rx_state_reg == RX_ERRSIG && !rx_sample
    |=> !txd_reg) else $error("error signal not driven");

  c_tx_frame: cover property (tx_last_end && !sync_mode);
  c_rx_frame: cover property (rx_done && !rx_full_reg);
  c_overrun: cover property (rx_done && rx_full_reg);
  c_resend: cover property (tx_state_reg == TX_GUARD && tx_resend_reg && tx_adv);
endmodule : sid_serial_channel

// ==== verif/sid_line_partner.sv ====
// Purpose: remote serial device on the line, start, data LSB first, stop
// Assumes: rate register 0, so one bit lasts 16 clocks
// Notes:   every frame seen on the line is kept with its start time
`timescale 1ns/1ps
module sid_line_partner (
  input  wire logic i_clock,
  input  wire logic i_line_in,
  output logic      o_line_out
);
  logic [7:0] got_q[$];
  time        t_q[$];
  logic [7:0] sh;
  initial o_line_out = 1'b1;
  // Start bit, n bits from the vector, high stop bit
  task automatic send(input logic [9:0] bits, input int n);
    o_line_out <= 1'b0;
    repeat (16) @(posedge i_clock);
    for (int i = 0; i < n; i++) begin
      o_line_out <= bits[i];
      repeat (16) @(posedge i_clock);
    end
    o_line_out <= 1'b1;
    repeat (16) @(posedge i_clock);
  endtask : send
  // Samples mid bit and waits to mid stop bit
  always begin
    @(negedge i_line_in);
    t_q.push_back($time);
    repeat (8) @(posedge i_clock);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge i_clock);
      sh[i] = i_line_in;
    end
    got_q.push_back(sh);
    repeat (16) @(posedge i_clock);
  end
endmodule : sid_line_partner

// ==== verif/sid_serial_channel_tb.sv ====
// Purpose: self-checking bench of the serial channel
// Assumes: rate 0, one bit is 16 clocks, serial clock pin runs at 400 ns
// Notes:   registers reached by classic Wishbone single cycles
`timescale 1ns/1ps
module sid_serial_channel_tb;
  import sid_pkg::*;
  logic        i_clock = 1'b0;
  logic        i_nrst  = 1'b0;
  logic        cyc     = 1'b0;
  logic        stb     = 1'b0;
  logic        we      = 1'b0;
  logic [7:0]  adr     = 8'h00;
  logic [31:0] wdat    = 32'h0;
  logic [31:0] rdat;
  logic [31:0] odat;
  logic        ack, rxd, txd, tx_end, rx_err;
  logic        sck_out, sck_oe_n, req_empty, req_full, xtx, xrx;
  logic        sck     = 1'b1;
  logic [3:0]  sel     = 4'h0;
  int          err_total = 0;
  int          samples_checked = 0;
  int          n_xtx   = 0;
  int          n_xrx   = 0;
  sid_line_partner peer (.i_clock(i_clock), .i_line_in(txd), .o_line_out(rxd));
  sid_serial_channel uut (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(odat), .o_wb_ack(ack),
    .i_rxd(rxd), .o_txd(txd), .i_sck(sck), .o_sck(sck_out), .o_sck_oe_n(sck_oe_n), .o_req_tx_end(tx_end),
    .o_req_tx_empty(req_empty), .o_req_rx_full(req_full), .o_req_rx_error(rx_err), .o_xfer_tx_start(xtx),
    .o_xfer_rx_start(xrx)
  );
  always #25 i_clock = ~i_clock;
  // Serial clock pin, 8 clocks per period
  always begin
    repeat (4) @(posedge i_clock);
    sck <= ~sck;
  end
  // Counts transfer controller trigger pulses
  always @(posedge i_clock) begin
    if (xtx === 1'b1) begin
      n_xtx <= n_xtx + 1;
    end
    if (xrx === 1'b1) begin
      n_xrx <= n_xrx + 1;
    end
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hF;
    do begin
      @(posedge i_clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = odat;
    cyc  <= 1'b0;
    stb  <= 1'b0;
    sel  <= 4'h0;
    if (n >= 20) begin
      err_total++;
      test_done();
    end
    @(posedge i_clock);
  endtask : wb
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      wb(1'b0, ADDR_STATE, 32'h0);
      n++;
    end while (rdat[b] !== v && n < 400);
    if (n >= 400) begin
      err_total++;
      test_done();
    end
  endtask : poll
  task automatic rd_hold(input logic [31:0] exp);
    poll(ST_RX_FULL, 1'b1);
    chk({31'h0, req_full}, 32'h1);
    wb(1'b0, ADDR_RX_HOLD, 32'h0);
    chk(rdat, exp);
  endtask : rd_hold
  task automatic t_reset;
    wb(1'b0, ADDR_STATE, 32'h0);
    chk(rdat, (32'h1 << ST_TX_EMPTY) | (32'h1 << ST_TX_END) | (32'h1 << ST_RX_PIN));
    chk({30'h0, sck_out, sck_oe_n}, 32'h3);
    wb(1'b1, ADDR_RX_HOLD, 32'hFF);
    wb(1'b0, ADDR_RX_HOLD, 32'h0);
    chk(rdat, {24'h0, HOLD_RESET});
    wb(1'b0, 8'h18, 32'h0);
    chk(rdat, 32'h0);
  endtask : t_reset
  task automatic t_tx;
    wb(1'b1, ADDR_CTRL, 32'h3);
    wb(1'b1, ADDR_TX_HOLD, 32'hA5);
    wb(1'b0, ADDR_TX_HOLD, 32'h0);
    chk(rdat, 32'hA5);
    poll(ST_TX_EMPTY, 1'b1);
    chk({31'h0, req_empty}, 32'h1);
    wb(1'b1, ADDR_TX_HOLD, 32'h3C);
    poll(ST_TX_END, 1'b1);
    chk({31'h0, tx_end}, 32'h1);
    chk({24'h0, peer.got_q[0]}, 32'hA5);
    chk({24'h0, peer.got_q[1]}, 32'h3C);
    chk(32'(peer.t_q[1] - peer.t_q[0]), 32'd8000);
  endtask : t_tx
  task automatic t_rx;
    wb(1'b1, ADDR_TX_HOLD, 32'h96);
    peer.send({2'b11, 8'h5A}, 8);
    rd_hold(32'h5A);
    chk({24'h0, peer.got_q[2]}, 32'h96);
    peer.send({2'b11, 8'h11}, 8);
    peer.send({2'b11, 8'h22}, 8);
    wb(1'b0, ADDR_STATE, 32'h0);
    chk({31'h0, rdat[ST_OVERRUN]}, 32'h1);
    chk({31'h0, rx_err}, 32'h1);
    rd_hold(32'h11);
    wb(1'b1, ADDR_STATE, 32'h1 << ST_OVERRUN);
    chk({31'h0, rx_err}, 32'h0);
  endtask : t_rx
  task automatic t_err;
    peer.send({2'b10, 8'h00}, 9);
    wb(1'b0, ADDR_STATE, 32'h0);
    chk({31'h0, rdat[ST_FRAMING]}, 32'h1);
    rd_hold(32'h00);
    wb(1'b1, ADDR_STATE, 32'h1 << ST_FRAMING);
    wb(1'b1, ADDR_MODE, 32'h1 << MODE_PAR_EN);
    peer.send({2'b10, 8'h01}, 9);
    wb(1'b0, ADDR_STATE, 32'h0);
    chk(rdat[4:2], 3'b100);
    rd_hold(32'h01);
    wb(1'b1, ADDR_STATE, 32'h1 << ST_PARITY);
  endtask : t_err
  task automatic t_fmt;
    wb(1'b1, ADDR_MODE, 32'h1 << MODE_CHAR7);
    peer.send({3'b111, 7'h7F}, 7);
    rd_hold(32'h7F);
    wb(1'b1, ADDR_MODE, 32'h1 << MODE_MSB);
    peer.send({2'b11, 8'h01}, 8);
    rd_hold(32'h80);
    wb(1'b1, ADDR_MODE, 32'h1 << MODE_TWO_STOP);
    peer.send({2'b11, 8'h33}, 8);
    peer.send({2'b11, 8'h44}, 8);
    wb(1'b0, ADDR_STATE, 32'h0);
    chk(rdat[4:2], 3'b001);
    rd_hold(32'h33);
    wb(1'b1, ADDR_STATE, 32'h1 << ST_OVERRUN);
  endtask : t_fmt
  task automatic t_modes;
    wb(1'b1, ADDR_MODE, 32'h1 << MODE_EXT_CLK);
    wb(1'b1, ADDR_TX_HOLD, 32'hFF);
    repeat (60) @(posedge i_clock);
    chk({31'h0, txd}, 32'h0);
    chk({31'h0, sck_oe_n}, 32'h1);
    wb(1'b1, ADDR_CTRL, 32'h0);
    wb(1'b1, ADDR_MODE, 32'h1 << MODE_SYNC);
    wb(1'b1, ADDR_CTRL, 32'h3);
    rd_hold(32'hFF);
    wb(1'b0, ADDR_STATE, 32'h0);
    chk({28'h0, rdat[4:2], sck_oe_n}, 32'h0);
    wb(1'b1, ADDR_CTRL, 32'h0);
    wb(1'b1, ADDR_MODE, 32'h1 << MODE_SMART);
    wb(1'b1, ADDR_CTRL, 32'h3);
    peer.send({2'b10, 8'h01}, 9);
    chk({31'h0, txd}, 32'h0);
    rd_hold(32'h01);
    wb(1'b1, ADDR_STATE, 32'h1 << ST_PARITY);
    chk(n_xtx, 32'd4);
    chk(n_xrx, 32'd9);
  endtask : t_modes
  initial begin
    repeat (3) @(posedge i_clock);
    i_nrst <= 1'b1;
    @(posedge i_clock);
    t_reset();
    t_tx();
    t_rx();
    t_err();
    t_fmt();
    t_modes();
    test_done();
  end
endmodule : sid_serial_channel_tb
